// [hdl/pin_mux.v]
// Drive level and pin function selection registers behind an APB slave.
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module pin_mux #(
  parameter LARGE = 1
) (
  input  wire        mclk_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [47:0] pin_level_i,
  output wire [95:0] drive_level_o,
  output wire [95:0] func_sel_o,
  output wire [47:0] key_enable_o,
  output wire [47:0] pin_oe_o,
  output wire [47:0] pin_in_o,
  output wire [2:0]  input_source_o
);
  localparam [4:0] NREG    = 3 + `NUM_FSEL + 1 + `NUM_PORTS;
  localparam [4:0] IDX_IFS = 3 + `NUM_FSEL;
  localparam [4:0] IDX_DIR = IDX_IFS + 1;

  // Maps a byte address to a register index; NREG means unmapped.
  function [4:0] decode;
    input [11:0] a;
    begin
      if (a[1:0] != 2'h0) begin
        decode = NREG;
      end else if (a <= `ADDR_DRIVE2) begin
        decode = {3'h0, a[3:2]};
      end else if (a >= `ADDR_FSEL_BASE &&
                   a < `ADDR_FSEL_BASE + 4 * `NUM_FSEL) begin
        decode = 5'h03 + a[6:2] - 5'h04;
      end else if (a == `ADDR_IFS) begin
        decode = IDX_IFS;
      end else if (a >= `ADDR_DIR_BASE &&
                   a < `ADDR_DIR_BASE + 4 * `NUM_PORTS) begin
        decode = IDX_DIR + a[6:2] - 5'h14;
      end else begin
        decode = NREG;
      end
    end
  endfunction

  // Implemented bits per register for the chosen variant.
  function [7:0] wmask;
    input integer i;
    begin
      if (i == 1) begin
        wmask = LARGE ? 8'hFF : `MASK_SIX;
      end else if (i == 2) begin
        wmask = LARGE ? `MASK_SIX : 8'h00;
      end else if (i == 9) begin
        wmask = LARGE ? 8'hFF : `MASK_FOUR;
      end else if (i == 10 || i == 11 || i == 12) begin
        wmask = LARGE ? 8'hFF : 8'h00;
      end else if (i == 3 + `FSEL_PFS) begin
        wmask = LARGE ? `MASK_FOUR : 8'h00;
      end else if (i == IDX_IFS) begin
        wmask = `MASK_IFS;
      end else if (i >= IDX_DIR + 5) begin
        wmask = LARGE ? 8'h03 : 8'h00;
      end else if (i == IDX_DIR + 4) begin
        wmask = LARGE ? 8'hFF : 8'h00;
      end else if (i == IDX_DIR + 3) begin
        wmask = LARGE ? 8'hFF : 8'h03;
      end else begin
        wmask = 8'hFF;
      end
    end
  endfunction

  wire [4:0]      idx = decode(paddr_i);
  wire            hit = (idx != NREG);
  wire            wr  = psel_i & penable_i & pwrite_i & hit;
  wire [8*NREG-1:0] regs;
  reg  [31:0]     prdata_reg;
  reg  [47:0]     pin_meta_reg;
  reg  [47:0]     pin_sync_reg;

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;
  assign prdata_o  = prdata_reg;

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gen_reg
      // writes act next cycle, reset loads 00, direction registers FF
      reg_cell #(
        .RESET_VAL (g >= IDX_DIR ? `DIR_RESET : `REG_RESET)
      ) u_cell (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .we_i    (wr && idx == g),
        .mask_i  (wmask(g)),
        .wdata_i (pwdata_i[7:0]),
        .q_o     (regs[8*g +: 8])
      );
    end
  endgenerate

  // read back of all selection registers
  always @(posedge mclk_i) begin
    if (reset_i) begin
      prdata_reg <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_reg <= hit ? {24'h000000, regs[8*idx +: 8]} : 32'h00000000;
    end
  end

  // Pin levels come from outside and pass two flip-flops.
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pin_meta_reg <= 48'h000000000000;
      pin_sync_reg <= 48'h000000000000;
    end else begin
      pin_meta_reg <= pin_level_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 48; p = p + 1) begin : gen_pin
      wire       hi   = (p % 8) >= 4;
      wire [1:0] lvl;
      if (p < 8) begin : g_a
        assign lvl = hi ? regs[3:2] : regs[1:0];
      end else if (p < 16) begin : g_b
        assign lvl = hi ? regs[7:6] : regs[5:4];
      end else if (p < 24) begin : g_c
        assign lvl = hi ? regs[11:10] : regs[9:8];
      end else if (p < 32) begin : g_d
        assign lvl = (LARGE && hi) ? regs[15:14] : regs[13:12];
      end else if (p < 40) begin : g_e
        assign lvl = hi ? regs[19:18] : regs[17:16];
      end else begin : g_f
        assign lvl = regs[21:20];
      end
      assign drive_level_o[2*p +: 2] = lvl;
      // per-pin function field, code 11 is touch key
      if (p < 44) begin : g_fs
        assign func_sel_o[2*p +: 2] = regs[8*(3 + p/4) + 2*(p%4) +: 2];
      end else begin : g_fz
        // Port F has no select register for pins 4 to 7.
        assign func_sel_o[2*p +: 2] = 2'h0;
      end
      assign key_enable_o[p] = (func_sel_o[2*p +: 2] == `FUNC_KEY);
      // direction 0 drives, 1 reads the pin
      assign pin_oe_o[p] = ~regs[8*IDX_DIR + p];
      assign pin_in_o[p] = regs[8*IDX_DIR + p] & pin_sync_reg[p];
    end
  endgenerate

  // input source selection for shared peripheral inputs
  assign input_source_o = regs[8*IDX_IFS +: 3];
endmodule

// [hdl/pin_mux_consts.vh]
// Register map, field positions and reset values of the pin mux block.
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH
`define ADDR_DRIVE0      12'h000
`define ADDR_DRIVE1      12'h004
`define ADDR_DRIVE2      12'h008
`define ADDR_FSEL_BASE   12'h010
`define ADDR_IFS         12'h040
`define ADDR_DIR_BASE    12'h050
`define NUM_FSEL         11
`define NUM_PORTS        6
`define FSEL_PFS         10
`define REG_RESET        8'h00
`define DIR_RESET        8'hFF
`define FUNC_KEY         2'h3
`define MASK_SIX         8'h3F
`define MASK_FOUR        8'h0F
`define MASK_IFS         8'h07
`endif

// [hdl/reg_cell.v]
// One 8-bit software register with write mask and reset value.
`timescale 1ns/1ps
module reg_cell #(
  parameter [7:0] RESET_VAL = 8'h00
) (
  input  wire       mclk_i,
  input  wire       reset_i,
  input  wire       we_i,
  input  wire [7:0] mask_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] q_o
);
  always @(posedge mclk_i) begin
    if (reset_i) begin
      q_o <= RESET_VAL;
    end else if (we_i) begin
      q_o <= wdata_i & mask_i;
    end
  end
endmodule

// [sim/pin_mux_asserts.sv]
// Concurrent checks on the pin mux register and pin outputs.
`timescale 1ns/1ps
module pin_mux_asserts (
  input wire        mclk_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire [95:0] drive_level_o,
  input wire [95:0] func_sel_o,
  input wire [47:0] key_enable_o,
  input wire [47:0] pin_oe_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  wire       w = psel_i & penable_i & pwrite_i;
  wire [7:0] d = pwdata_i[7:0];
  chk_key_sel: assert property (
    key_enable_o[0] == (func_sel_o[1:0] == 2'h3)) else $error("key");
  chk_drive_a: assert property (w && paddr_i == 12'h000 |=>
    drive_level_o[15:0] == {{4{$past(d[3:2])}}, {4{$past(d[1:0])}}})
    else $error("drive a");
  chk_drive_c: assert property (w && paddr_i == 12'h004 |=>
    drive_level_o[47:32] == {{4{$past(d[3:2])}}, {4{$past(d[1:0])}}})
    else $error("drive c");
  chk_drive_d: assert property (w && paddr_i == 12'h004 |=>
    drive_level_o[63:48] == {{4{$past(d[7:6])}}, {4{$past(d[5:4])}}})
    else $error("drive d");
  chk_drive_ef: assert property (w && paddr_i == 12'h008 |=>
    drive_level_o[83:64] == {{2{$past(d[5:4])}}, {4{$past(d[3:2])}},
    {4{$past(d[1:0])}}}) else $error("drive e f");
  chk_read_top: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == 12'h008 |->
    prdata_o[31:6] == 26'h0) else $error("top bits");
  chk_func_a: assert property (w && paddr_i == 12'h010 |=>
    func_sel_o[7:0] == $past(d)) else $error("func a");
  chk_reset_clr: assert property ($past(reset_i) |->
    drive_level_o == 96'h0 && func_sel_o == 96'h0 && pin_oe_o == 48'h0)
    else $error("reset");
endmodule
bind pin_mux pin_mux_asserts pin_mux_asserts_inst (.mclk_i, .reset_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .drive_level_o, .func_sel_o, .key_enable_o, .pin_oe_o);

// [sim/testbench.sv]
// Self-checking bench for the pin mux block.
`timescale 1ns/1ps
module testbench;
  reg         mclk_i, reset_i, psel_i, penable_i, pwrite_i, err_q;
  reg  [11:0] paddr_i;
  reg  [31:0] pwdata_i, rd_q;
  reg  [47:0] pin_level_i;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o;
  wire [95:0] drive_level_o, func_sel_o;
  wire [47:0] key_enable_o, pin_oe_o, pin_in_o;
  wire [2:0]  input_source_o;
  integer     err_count, n_tests, cyc, v;
  pin_mux pin_mux_inst (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_level_i,
    .drive_level_o, .func_sel_o, .key_enable_o, .pin_oe_o, .pin_in_o,
    .input_source_o);
  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  task chk(input [95:0] s, input [95:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input wr, input [11:0] a, input [7:0] dat);
    @(posedge mclk_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, dat};
    @(posedge mclk_i);
    penable_i <= 1'h1;
    do @(posedge mclk_i); while (pready_o !== 1'h1);
    rd_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task t_reset;
    chk(drive_level_o, 96'h0);
    chk(func_sel_o, 96'h0);
    chk(pin_oe_o, 48'h0);
    chk(pready_o, 96'h1);
    apb(1'h0, 12'h004, 8'h0);
    chk(rd_q, 32'h0);
  endtask
  task t_drive;
    for (v = 0; v < 4; v = v + 1) begin
      apb(1'h1, 12'h000, {4'h0, v[1:0], 2'h3 - v[1:0]});
      @(posedge mclk_i);
      chk(drive_level_o[15:0], {{4{v[1:0]}}, {4{2'h3 - v[1:0]}}});
    end
    apb(1'h1, 12'h004, 8'hE4);
    @(posedge mclk_i);
    chk(drive_level_o[63:32], 32'hFFAA5500);
    apb(1'h1, 12'h008, 8'hF9);
    apb(1'h0, 12'h008, 8'h0);
    chk(rd_q, 32'h39);
    chk(drive_level_o[83:64], 20'hFAA55);
  endtask
  task t_func;
    apb(1'h1, 12'h010, 8'hC3);
    @(posedge mclk_i);
    chk({func_sel_o[7:0], key_enable_o[3:0]}, 12'hC39);
    apb(1'h1, 12'h040, 8'hFF);
    apb(1'h0, 12'h040, 8'h0);
    chk({input_source_o, rd_q}, 35'h700000007);
    apb(1'h0, 12'h0FC, 8'h0);
    chk({err_q, rd_q}, 33'h100000000);
    apb(1'h1, 12'h050, 8'h0F);
    pin_level_i <= 48'hFF;
    repeat (3) @(posedge mclk_i);
    chk({pin_oe_o[7:0], pin_in_o[7:0]}, 16'hF00F);
  endtask
  task t_share;
    // pin function first, peripheral set up afterwards
    apb(1'h1, 12'h014, 8'h04);
    // data line routed out and picked as input source
    apb(1'h1, 12'h040, 8'h02);
    // direction bit set to input for the interrupt pin
    apb(1'h1, 12'h050, 8'h40);
    pin_level_i <= 48'h40;
    repeat (3) @(posedge mclk_i);
    chk(func_sel_o[13:10], 4'h1);
    chk(input_source_o, 3'h2);
    chk({pin_oe_o[6], pin_in_o[6]}, 2'h1);
    // field released, input source left at 2
    apb(1'h1, 12'h014, 8'h00);
    @(posedge mclk_i);
    chk(func_sel_o[11:10], 2'h0);
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  initial begin
    reset_i = 1'h1;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 47'h0;
    pin_level_i = 48'h0;
    {err_count, n_tests, cyc} = 96'h0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'h0;
    t_reset;
    t_drive;
    t_func;
    t_share;
    reset_i <= 1'h1;
    @(posedge mclk_i);
    reset_i <= 1'h0;
    @(posedge mclk_i);
    t_reset;
    finish_test;
  end
endmodule
